// >>> rtl/rvsm_pkg.sv
// constants, types and helpers of the ram, vector and stack map block
// Operation
// - provide 1024 bytes of read/write ram
// - addresses 0x0050 to 0x044f hit the ram
// - 176 ram bytes lie in page zero
// - stack pointer resets to 0x00ff
// - stack pointer is 16 bits, full space
// - interrupt entry pushes five context bytes
// - high index byte is never stacked
// - subroutine call pushes two return bytes
// - push decrements, pull increments stack pointer
// - vectors fetched from 0xffcc to 0xffff
// - vector priority rises with address
// - vectors high byte even, fixed pairs listed
// - timer a vectors from 0xffec to 0xfff4
package rvsm_pkg;

  // ram window
  localparam int unsigned RAM_BYTES     = 1024;
  localparam logic [15:0] RAM_FIRST     = 16'h0050;
  localparam logic [15:0] RAM_LAST      = 16'h044f;
  localparam logic [15:0] PAGE0_LAST    = 16'h00ff;
  localparam int unsigned PAGE0_RAM     = 176;

  // stack pointer and stacking depths
  localparam logic [15:0] SP_RESET      = 16'h00ff;
  localparam logic [2:0]  INT_STACK_N   = 3'h5;
  localparam logic [2:0]  CALL_STACK_N  = 3'h2;

  // vector table: one pair per source, index 0 is the lowest priority
  localparam logic [15:0] VEC_FIRST     = 16'hffcc;
  localparam logic [15:0] VEC_LAST      = 16'hffff;
  localparam int unsigned VEC_COUNT     = 26;
  localparam logic [15:0] VEC_TMRB_CH0  = 16'hffea;
  localparam logic [15:0] VEC_TMRA_OVF  = 16'hffec;
  localparam logic [15:0] VEC_TMRA_CH3  = 16'hffee;
  localparam logic [15:0] VEC_TMRA_CH2  = 16'hfff0;
  localparam logic [15:0] VEC_TMRA_CH1  = 16'hfff2;
  localparam logic [15:0] VEC_TMRA_CH0  = 16'hfff4;
  localparam logic [15:0] VEC_PERIODIC  = 16'hfff6;
  localparam logic [15:0] VEC_LOOP      = 16'hfff8;
  localparam logic [15:0] VEC_EXT_ONE   = 16'hfffa;
  localparam logic [15:0] VEC_SOFT_INT  = 16'hfffc;
  localparam logic [15:0] VEC_RESET     = 16'hfffe;

  // sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PUSH = 1'b1
  } rvsm_state_type;

  // true when an address falls in the ram window
  function automatic logic rvsm_in_ram(input logic [15:0] a);
    return (a >= RAM_FIRST) && (a <= RAM_LAST);
  endfunction : rvsm_in_ram

  // byte index of an address inside the ram array
  function automatic logic [9:0] rvsm_ram_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - RAM_FIRST;
    return d[9:0];
  endfunction : rvsm_ram_idx

endpackage : rvsm_pkg

// >>> rtl/rvsm_vec_prio.sv
// vector priority encoder: highest pending source and its vector address
module rvsm_vec_prio
  import rvsm_pkg::*;
(
  input  wire logic [VEC_COUNT-1:0] req_i,   // one request per pair
  output logic                      found_o, // any request pending
  output logic      [4:0]           idx_o,   // winning pair index
  output logic      [15:0]          addr_o   // high byte address of pair
);

  // scan upward so the highest address wins
  always_comb begin
    found_o = 1'b0;
    idx_o   = 5'h00;
    for (int i = 0; i < VEC_COUNT; i++) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        idx_o   = 5'(i);
      end
    end
    // pairs sit two bytes apart, high byte on the even address
    addr_o = VEC_FIRST + {10'h000, idx_o, 1'b0};
  end

endmodule : rvsm_vec_prio

// >>> rtl/rvsm_top.sv
// ram decode, stack pointer, stacking sequencer and vector selection
module rvsm_top
  import rvsm_pkg::*;
(
  input  wire logic                 clk_i,          // 20 mhz system clock
  input  wire logic                 arst_n_i,       // async reset, low
  input  wire logic [15:0]          bus_addr_i,     // cpu address
  input  wire logic [7:0]           bus_wdata_i,    // cpu write data
  input  wire logic                 bus_wr_i,       // cpu write strobe
  input  wire logic                 bus_rd_i,       // cpu read strobe
  input  wire logic                 int_entry_i,    // start interrupt entry
  input  wire logic                 call_i,         // start subroutine call
  input  wire logic                 pull_i,         // pull one byte
  // set the stack pointer back to its reset value
  input  wire logic                 reset_stack_pointer_instruction_i,
  input  wire logic                 sp_load_i,      // load stack pointer
  input  wire logic [15:0]          sp_load_val_i,  // value for the load
  input  wire logic [15:0]          pc_i,           // pc or return address
  input  wire logic [7:0]           acc_i,          // accumulator
  input  wire logic [7:0]           x_i,            // low index byte
  input  wire logic [7:0]           ccr_i,          // condition codes
  input  wire logic [VEC_COUNT-1:0] irq_req_i,      // pending vector pairs
  output logic      [7:0]           rd_data_o,      // read or pulled byte
  output logic                      rd_valid_o,     // read data pulse
  output logic                      ram_sel_o,      // last access hit ram
  output logic      [15:0]          sp_o,           // stack pointer
  output logic                      busy_o,         // stacking in progress
  output logic                      done_o,         // stacking finished
  output logic      [15:0]          vec_addr_o,     // vector to fetch
  output logic                      vec_valid_o,    // vector ready pulse
  output logic                      stack_fault_o   // stack left the ram
);

  // whole block state in one record
  typedef struct packed {
    logic [RAM_BYTES-1:0][7:0] mem;      // ram array
    logic [15:0]               sp;       // stack pointer
    rvsm_state_type            state;    // sequencer state
    logic [39:0]               ctx;      // bytes still to push, low first
    logic [2:0]                left;     // pushes remaining
    logic                      is_int;   // sequence is an interrupt entry
    logic [4:0]                vidx;     // pair latched at entry
    logic [7:0]                rd_data;  // read result
    logic                      rd_valid; // read pulse
    logic                      ram_sel;  // ram hit of last access
    logic                      busy;     // sequencer busy
    logic                      done;     // sequence end pulse
    logic [15:0]               vec_addr; // selected vector
    logic                      vec_valid;// vector pulse
    logic                      fault;    // stack access outside ram
  } rvsm_regs_type;

  rvsm_regs_type s;        // registered state
  rvsm_regs_type next_s;   // next state

  logic          pr_found; // a source is pending
  logic [4:0]    pr_idx;   // highest pending pair

  // priority choice among pending sources
  rvsm_vec_prio u_prio (
    .req_i   (irq_req_i),
    .found_o (pr_found),
    .idx_o   (pr_idx),
    .addr_o  ()
  );

  // next-state logic
  always_comb begin
    next_s           = s;
    next_s.rd_valid  = 1'b0;
    next_s.done      = 1'b0;
    next_s.vec_valid = 1'b0;
    next_s.fault     = 1'b0;
    unique case (s.state)
      ST_IDLE: begin
        if (int_entry_i) begin
          // pcl goes first, h is never offered to the stack
          next_s.ctx    = {ccr_i, acc_i, x_i, pc_i[15:8], pc_i[7:0]};
          next_s.left   = INT_STACK_N;
          next_s.is_int = 1'b1;
          // no pending source falls back to the reset pair
          next_s.vidx   = pr_found ? pr_idx : 5'(VEC_COUNT - 1);
          next_s.state  = ST_PUSH;
          next_s.busy   = 1'b1;
        end else if (call_i) begin
          next_s.ctx    = {24'h000000, pc_i[15:8], pc_i[7:0]};
          next_s.left   = CALL_STACK_N;
          next_s.is_int = 1'b0;
          next_s.state  = ST_PUSH;
          next_s.busy   = 1'b1;
        end else if (pull_i) begin
          // pre-increment, then read the byte now on top
          next_s.sp       = s.sp + 16'h0001;
          next_s.rd_valid = 1'b1;
          if (rvsm_in_ram(next_s.sp)) begin
            next_s.rd_data = s.mem[rvsm_ram_idx(next_s.sp)];
          end else begin
            // a stack outside ram reads nothing useful
            next_s.rd_data = 8'h00;
            next_s.fault   = 1'b1;
          end
        end else if (reset_stack_pointer_instruction_i) begin
          next_s.sp = SP_RESET;
        end else if (sp_load_i) begin
          next_s.sp = sp_load_val_i;
        end else if (bus_wr_i || bus_rd_i) begin
          next_s.ram_sel = rvsm_in_ram(bus_addr_i);
          if (bus_wr_i && rvsm_in_ram(bus_addr_i)) begin
            next_s.mem[rvsm_ram_idx(bus_addr_i)] = bus_wdata_i;
          end
          if (bus_rd_i) begin
            next_s.rd_valid = 1'b1;
            // unmapped reads return zero and touch no ram cell
            next_s.rd_data  = rvsm_in_ram(bus_addr_i) ?
                              s.mem[rvsm_ram_idx(bus_addr_i)] : 8'h00;
          end
        end
      end
      ST_PUSH: begin
        // write at sp then post-decrement; stray stacks are dropped
        if (rvsm_in_ram(s.sp)) begin
          next_s.mem[rvsm_ram_idx(s.sp)] = s.ctx[7:0];
        end else begin
          next_s.fault = 1'b1;
        end
        next_s.sp   = s.sp - 16'h0001;
        next_s.ctx  = {8'h00, s.ctx[39:8]};
        next_s.left = s.left - 3'h1;
        if (s.left == 3'h1) begin
          next_s.state = ST_IDLE;
          next_s.busy  = 1'b0;
          next_s.done  = 1'b1;
          if (s.is_int) begin
            // vector is known only once the context is safe
            next_s.vec_addr  = VEC_FIRST + {10'h000, s.vidx, 1'b0};
            next_s.vec_valid = 1'b1;
          end
        end
      end
    endcase
  end

  // state register; the array reset clears the ram and the record, but sp loads 0x00ff and vec_addr 0xfffe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s          <= '0;
      s.sp       <= SP_RESET;
      s.state    <= ST_IDLE;
      s.vec_addr <= VEC_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state record
  assign rd_data_o     = s.rd_data;
  assign rd_valid_o    = s.rd_valid;
  assign ram_sel_o     = s.ram_sel;
  assign sp_o          = s.sp;
  assign busy_o        = s.busy;
  assign done_o        = s.done;
  assign vec_addr_o    = s.vec_addr;
  assign vec_valid_o   = s.vec_valid;
  assign stack_fault_o = s.fault;

  // accepted commands, as the idle sequencer sees them
  logic acc_int;      // interrupt entry taken
  logic acc_call;     // call taken
  logic acc_pull;     // pull taken
  logic acc_reset_sp; // stack pointer reset taken
  logic acc_bus;      // bus access taken
  assign acc_int      = !busy_o && int_entry_i;
  assign acc_call     = !busy_o && !int_entry_i && call_i;
  assign acc_pull     = !busy_o && !int_entry_i && !call_i && pull_i;
  assign acc_reset_sp = !busy_o && !int_entry_i && !call_i && !pull_i &&
                        reset_stack_pointer_instruction_i;
  assign acc_bus      = !busy_o && !int_entry_i && !call_i && !pull_i &&
                        !reset_stack_pointer_instruction_i && !sp_load_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_int_push_len: assert property (
    acc_int |=> busy_o [*5] ##1 (!busy_o && done_o))
    else $error("interrupt entry did not stack five bytes");
  chk_int_sp_step: assert property (
    acc_int |-> ##6 (sp_o == $past(sp_o, 6) - 16'h0005))
    else $error("sp not lowered by five after interrupt entry");
  chk_call_push_len: assert property (
    acc_call |=> busy_o [*2] ##1 (!busy_o && done_o && !vec_valid_o))
    else $error("call did not stack two bytes");
  chk_call_sp_step: assert property (
    acc_call |-> ##3 (sp_o == $past(sp_o, 3) - 16'h0002))
    else $error("sp not lowered by two after call");
  chk_pull_sp_up: assert property (
    acc_pull |=> (sp_o == $past(sp_o) + 16'h0001) && rd_valid_o)
    else $error("pull did not raise sp by one");
  chk_reset_sp_value: assert property (
    acc_reset_sp |=> sp_o == 16'h00ff)
    else $error("stack pointer reset gave a wrong value");
  chk_unmapped_no_sel: assert property (
    acc_bus && (bus_wr_i || bus_rd_i) && !rvsm_in_ram(bus_addr_i)
    |=> !ram_sel_o)
    else $error("unmapped access selected the ram");
  chk_ram_readback: assert property (
    (acc_bus && bus_wr_i && !bus_rd_i && rvsm_in_ram(bus_addr_i))
    ##1 (acc_bus && bus_rd_i && !bus_wr_i &&
         bus_addr_i == $past(bus_addr_i))
    |=> rd_data_o == $past(bus_wdata_i, 2))
    else $error("ram did not return the written byte");
  chk_vec_pair: assert property (
    vec_valid_o |-> vec_addr_o >= 16'hffcc && !vec_addr_o[0] && done_o)
    else $error("vector outside table or on odd address");

  cov_int_entry: cover property (acc_int ##6 vec_valid_o);
  cov_call: cover property (acc_call ##3 done_o);
  cov_pull: cover property (acc_pull ##1 rd_valid_o);
  cov_stray_stack: cover property (stack_fault_o);

endmodule : rvsm_top

// >>> test/rvsm_cpu_model.sv
// cpu core model: drives bus cycles and stacking commands of the map
module rvsm_cpu_model
  import rvsm_pkg::*;
(
  input  wire logic                 clk_i,   // system clock
  input  wire logic                 done_i,  // stacking finished
  output logic      [15:0]          addr_o,  // bus address
  output logic      [7:0]           wdata_o, // write data
  output logic                      wr_o,    // write strobe
  output logic                      rd_o,    // read strobe
  output logic      [4:0]           cmd_o,   // int,call,pull,sp reset,load
  output logic      [15:0]          val_o,   // pc or stack load value
  output logic      [VEC_COUNT-1:0] irq_o    // pending vector pairs
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle core: no strobe, no command
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    cmd_o   = '0;
    val_o   = '0;
    irq_o   = '0;
  end

  // one bus cycle, strobe held for exactly one clock
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = w;
    rd_o    = !w;
    @(negedge clk_i);
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    // released data no longer shows the old byte
    wdata_o = ~d;
  endtask : access

  // write then read of one address on two back-to-back clocks
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    rd_o    = 1'b1;
    @(negedge clk_i);
    rd_o    = 1'b0;
    wdata_o = ~d;
  endtask : wr_rd

  // one command pulse, then wait up to n cycles for done
  // the caller only aims the stack at ram before stacking
  task automatic cmd(input logic [4:0] k, input logic [15:0] v,
                     input logic [VEC_COUNT-1:0] q, input int n);
    int i;
    @(negedge clk_i);
    cmd_o = k;
    val_o = v;
    irq_o = q;
    @(negedge clk_i);
    cmd_o = '0;
    for (i = 0; i < n && done_i !== 1'b1; i++) @(negedge clk_i);
  endtask : cmd

endmodule : rvsm_cpu_model

// >>> test/rvsm_top_tb_top.sv
// self-checking bench of the ram, vector and stack map block
module rvsm_top_tb_top
  import rvsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // one-hot commands: int, call, pull, sp reset, load
  localparam logic [4:0] C_INT      = 5'h10;
  localparam logic [4:0] C_CALL     = 5'h08;
  localparam logic [4:0] C_PULL     = 5'h04;
  localparam logic [4:0] C_RESET_SP = 5'h02;
  localparam logic [4:0] C_LOAD     = 5'h01;
  // fixed context bytes, distinct so stacking order shows
  localparam logic [7:0] ACC = 8'ha1;
  localparam logic [7:0] XLO = 8'hb2;
  localparam logic [7:0] CCR = 8'hc3;

  logic                 clk;       // system clock
  logic                 arst_n;    // reset, low
  logic [15:0]          addr;      // bus address
  logic [7:0]           wdata;     // write data
  logic                 wr;        // write strobe
  logic                 rd;        // read strobe
  logic [4:0]           cmd;       // command pulses
  logic [15:0]          val;       // pc or load value
  logic [VEC_COUNT-1:0] irq;       // pending pairs
  logic [7:0]           rd_data;   // read byte
  logic                 rd_valid;  // read pulse
  logic                 ram_sel;   // ram hit
  logic [15:0]          sp;        // stack pointer
  logic                 done;      // stacking done
  logic                 busy;      // stacking in progress
  logic                 stack_fault; // push or pull outside ram
  logic [15:0]          vec_addr;  // vector address
  logic                 vec_valid; // vector pulse
  int                   errors;    // mismatches
  int                   n_tests;   // comparisons

  // 20 mhz clock
  always #25 clk = ~clk;

  rvsm_cpu_model cpu (.clk_i(clk), .done_i(done), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .val_o(val),
    .irq_o(irq));

  rvsm_top uut (.clk_i(clk), .arst_n_i(arst_n), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd),
    .int_entry_i(cmd[4]), .call_i(cmd[3]), .pull_i(cmd[2]),
    .reset_stack_pointer_instruction_i(cmd[1]), .sp_load_i(cmd[0]),
    .sp_load_val_i(val), .pc_i(val), .acc_i(ACC), .x_i(XLO), .ccr_i(CCR),
    .irq_req_i(irq), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .ram_sel_o(ram_sel), .sp_o(sp), .busy_o(busy), .done_o(done),
    .vec_addr_o(vec_addr), .vec_valid_o(vec_valid),
    .stack_fault_o(stack_fault));

  // verdict and end of run
  task automatic stop_test();
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // counted comparison; four-state so unknowns fail
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // read one byte and judge data and ram hit
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e,
                       input logic s);
    cpu.access(1'b0, a, 8'h00);
    chk("rd_valid", 16'h1, {15'h0, rd_valid});
    chk("rd_data", {8'h0, e}, {8'h0, rd_data});
    chk("ram_sel", {15'h0, s}, {15'h0, ram_sel});
  endtask : rdchk

  // ram edges, page zero top, and misses that must not alias
  task automatic t_ram();
    logic [15:0] a [3];
    int i;
    a = '{16'h0050, 16'h00ff, 16'h044f};
    for (i = 0; i < 3; i++) cpu.access(1'b1, a[i], a[i][7:0] ^ 8'h3c);
    for (i = 0; i < 3; i++) rdchk(a[i], a[i][7:0] ^ 8'h3c, 1'b1);
    cpu.access(1'b1, 16'h0450, 8'hff);
    cpu.access(1'b1, 16'h004f, 8'hff);
    rdchk(16'h0450, 8'h00, 1'b0);
    rdchk(16'h004f, 8'h00, 1'b0);
    rdchk(16'h0050, 8'h6c, 1'b1);
    rdchk(16'h044f, 8'h73, 1'b1);
    // read straight after the write, no idle clock between
    cpu.wr_rd(16'h0200, 8'h9d);
    chk("wr_rd_data", 16'h009d, {8'h0, rd_data});
  endtask : t_ram

  // call stacks two bytes low first, pull climbs back
  task automatic t_call();
    cpu.cmd(C_LOAD, 16'h0300, '0, 0);
    cpu.cmd(C_CALL, 16'h1234, '0, 6);
    chk("call_done", 16'h1, {15'h0, done});
    chk("call_busy", 16'h0, {15'h0, busy});
    chk("sp", 16'h02fe, sp);
    rdchk(16'h0300, 8'h34, 1'b1);
    rdchk(16'h02ff, 8'h12, 1'b1);
    cpu.cmd(C_PULL, 16'h0000, '0, 0);
    chk("pull_data", 16'h0012, {8'h0, rd_data});
    chk("sp", 16'h02ff, sp);
  endtask : t_call

  // interrupt stacking and vector choice over the pair table
  task automatic t_int();
    logic [VEC_COUNT-1:0] q [6];
    logic [15:0] v [6];
    logic [7:0] e [6];
    int i;
    q = '{26'h0, 26'h1, 26'h8001, 26'h10000, 26'h100000, 26'h2000002};
    v = '{16'hfffe, 16'hffcc, 16'hffea, 16'hffec, 16'hfff4, 16'hfffe};
    e = '{8'h76, 8'h98, XLO, ACC, CCR, 8'h5a};
    // guard byte just below the five stacked bytes
    cpu.access(1'b1, 16'h02fb, 8'h5a);
    for (i = 0; i < 6; i++) begin
      cpu.cmd(C_LOAD, 16'h0300, '0, 0);
      cpu.cmd(C_INT, 16'h9876, q[i], 10);
      chk("vec_valid", 16'h1, {15'h0, vec_valid});
      chk("vec_addr", v[i], vec_addr);
      chk("sp", 16'h02fb, sp);
    end
    for (i = 0; i < 6; i++) rdchk(16'h0300 - 16'(i), e[i], 1'b1);
  endtask : t_int

  // full-width load, then the reset stack pointer instruction
  task automatic t_sp();
    cpu.cmd(C_LOAD, 16'hffff, '0, 0);
    chk("sp", 16'hffff, sp);
    // a pull from the top wraps to 0x0000, outside ram
    cpu.cmd(C_PULL, 16'h0000, '0, 0);
    chk("sp", 16'h0000, sp);
    chk("stack_fault", 16'h1, {15'h0, stack_fault});
    chk("fault_data", 16'h0000, {8'h0, rd_data});
    cpu.cmd(C_RESET_SP, 16'h0000, '0, 0);
    chk("sp", 16'h00ff, sp);
  endtask : t_sp

  // main sequence
  initial begin
    clk     = 1'b0;
    arst_n  = 1'b0;
    errors  = 0;
    n_tests = 0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    chk("sp_reset", 16'h00ff, sp);
    chk("vec_reset", 16'hfffe, vec_addr);
    t_ram();
    t_call();
    t_int();
    t_sp();
    stop_test();
  end

  // watchdog: about 125 cycles are needed, allow 4000
  initial begin
    #(50 * 4000);
    errors++;
    stop_test();
  end

endmodule : rvsm_top_tb_top
